/* File: rtl/mesa_monitor.sv */
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "mesa_map.svh"
module mesa_monitor #(
    parameter int unsigned SLOT_CYCLES = 100000
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        ext_reset_n_i,
    output logic             ext_reset_n_o,
    output logic             ext_reset_n_oe,
    input  wire logic [2:0]  addr_select,
    input  wire logic        bus_activity,
    input  wire logic        volt_event,
    input  wire logic        temp_event,
    input  wire logic        diode_event,
    input  wire logic [1:0]  gpi_event,
    input  wire logic        user_throttle_event,
    input  wire logic        processor_throttle_signal,
    input  wire logic        fan_event,
    input  wire logic        termination_sense_input,
    input  wire logic        regulator_overheat_input,
    output logic             controller_error_output,
    output logic             host_error_output,
    output logic             alert_n,
    output logic [4:0]       channel,
    output logic             pass_done
);
    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    localparam int NS = 15;
    logic [NS-1:0] raw_in;
    logic [NS-1:0] syn;
    assign raw_in = {ext_reset_n_i, addr_select, bus_activity, volt_event, temp_event,
                     diode_event, gpi_event, user_throttle_event, processor_throttle_signal,
                     fan_event, termination_sense_input, regulator_overheat_input};
    mesa_sync #(.W(NS)) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (raw_in),
        .q       (syn)
    );
    wire       ext_rst_s = ~syn[14];
    wire [2:0] sel_s     = syn[13:11];
    wire       bus_s     = syn[10];
    wire [`MESA_EV_WIDTH-1:0] cause = {syn[3], syn[0], syn[1], syn[2], syn[4], syn[6],
                                       syn[5], syn[7], syn[8], syn[9]};

    mesa_round_robin #(.SLOT_CYCLES(SLOT_CYCLES)) u_rr (
        .pclk        (pclk),
        .presetn     (presetn),
        .channel_q   (channel),
        .pass_done_q (pass_done)
    );

    // ------------------------------------------------------------
    // reset pin: released after power-on, then an input
    // ------------------------------------------------------------
    logic por_done_q;
    logic ext_rst_q;
    assign ext_reset_n_o  = 1'b0;
    assign ext_reset_n_oe = por_done_q;
    wire ext_rst_edge = por_done_q & ext_rst_s & ~ext_rst_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            por_done_q <= 1'b0;
            // pin is low through power-on: start as already asserted, so no false edge
            ext_rst_q  <= 1'b1;
        end else begin
            por_done_q <= 1'b1;
            ext_rst_q  <= ext_rst_s;
        end
    end

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    wire acc   = psel & penable;
    wire wr    = acc & pwrite;
    wire rd    = acc & ~pwrite;
    wire a_cfg = (paddr == `MESA_ADDR_CONFIG);
    wire a_slp = (paddr == `MESA_ADDR_SLEEP);
    wire a_smk = (paddr == `MESA_ADDR_SLPMASK);
    wire a_gmk = (paddr == `MESA_ADDR_GPIMASK);
    wire a_mmk = (paddr == `MESA_ADDR_MISCMASK);
    wire a_evt = (paddr == `MESA_ADDR_EVENTS);
    wire a_cer = (paddr == `MESA_ADDR_CTRL_ERR);
    wire a_her = (paddr == `MESA_ADDR_HOST_ERR);
    wire a_sad = (paddr == `MESA_ADDR_SLAVE);
    wire a_chn = (paddr == `MESA_ADDR_CHANNEL);
    wire a_vl  = (paddr == `MESA_ADDR_VLIMIT);
    wire a_tl  = (paddr == `MESA_ADDR_TLIMIT);
    wire a_fl  = (paddr == `MESA_ADDR_FLIMIT);
    wire a_ul  = (paddr == `MESA_ADDR_ULIMIT);
    wire a_trk = (paddr == `MESA_ADDR_TRACKED);
    wire mapped = a_cfg | a_slp | a_smk | a_gmk | a_mmk | a_evt | a_cer | a_her |
                  a_sad | a_chn | a_vl | a_tl | a_fl | a_ul | a_trk;

    // ------------------------------------------------------------
    // configuration and mask registers
    // ------------------------------------------------------------
    logic [3:0]  cfg_q;
    logic [2:0]  sleep_q;
    logic [`MESA_EV_WIDTH-1:0] slpmask_q;
    logic [1:0]  gpimask_q;
    logic [1:0]  miscmask_q;
    logic [7:0]  vlim_q;
    logic [7:0]  tlim_q;
    logic [7:0]  flim_q;
    logic [15:0] ulim_q;
    logic        ulo_valid_q;
    logic [7:0]  ulo_buf_q;
    wire locked = cfg_q[`MESA_CFG_LOCK];
    wire lim_wr = wr & ~locked;
    // 16-bit user limit: byte 0 is buffered low byte, byte 1 commits both
    wire ulim_lo_wr = lim_wr & a_ul & ~pwdata[8];
    wire ulim_hi_wr = lim_wr & a_ul & pwdata[8];
    wire ulim_refuse = ulim_hi_wr & ~ulo_valid_q;
    assign pslverr = acc & (~mapped | ulim_refuse);
    assign pready  = 1'b1;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q <= 4'h0;
        end else if (ext_rst_edge) begin
            cfg_q[`MESA_CFG_LOCK] <= 1'b0;
            cfg_q[`MESA_CFG_GLOBAL_EVENT_MASK_BIT] <= 1'b1;
        end else if (wr & a_cfg) begin
            cfg_q <= {pwdata[3:1], pwdata[0] | locked};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sleep_q <= `MESA_SLEEP_S0;
        end else if (ext_rst_edge) begin
            sleep_q <= `MESA_SLEEP_DEEP;
        end else if (wr & a_slp) begin
            sleep_q <= pwdata[2:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slpmask_q   <= '0;
            gpimask_q   <= 2'h0;
            miscmask_q  <= 2'h0;
            vlim_q      <= `MESA_VOLT_MASKED;
            tlim_q      <= `MESA_TEMP_MASKED;
            flim_q      <= `MESA_FAN_MASKED;
            ulim_q      <= {8'h00, `MESA_USER_MASKED};
            ulo_valid_q <= 1'b0;
            ulo_buf_q   <= 8'h00;
        end else begin
            if (lim_wr & a_smk) slpmask_q <= pwdata[`MESA_EV_WIDTH-1:0];
            if (lim_wr & a_gmk) gpimask_q <= pwdata[1:0];
            if (lim_wr & a_mmk) miscmask_q <= pwdata[1:0];
            if (lim_wr & a_vl) vlim_q <= pwdata[7:0];
            if (lim_wr & a_tl) tlim_q <= pwdata[7:0];
            if (lim_wr & a_fl) flim_q <= pwdata[7:0];
            if (ulim_lo_wr) begin
                ulo_buf_q   <= pwdata[7:0];
                ulo_valid_q <= 1'b1;
            end else if (ulim_hi_wr) begin
                ulo_valid_q <= 1'b0;
                if (ulo_valid_q) ulim_q <= {pwdata[7:0], ulo_buf_q};
            end
        end
    end

    // ------------------------------------------------------------
    // event masking
    // ------------------------------------------------------------
    wire deep = (sleep_q == `MESA_SLEEP_DEEP);
    wire asleep = (sleep_q != `MESA_SLEEP_S0);
    logic [`MESA_EV_WIDTH-1:0] manual_mask;
    always_comb begin
        manual_mask = '0;
        manual_mask[`MESA_EV_VOLT]  = (vlim_q == `MESA_VOLT_MASKED);
        // temp limit 80h masks diode too
        manual_mask[`MESA_EV_TEMP]  = (tlim_q == `MESA_TEMP_MASKED);
        manual_mask[`MESA_EV_DIODE] = (tlim_q == `MESA_TEMP_MASKED);
        manual_mask[`MESA_EV_GPI_LO] = gpimask_q[0];
        manual_mask[`MESA_EV_GPI_HI] = gpimask_q[1];
        manual_mask[`MESA_EV_USER_THR] = (ulim_q[7:0] == `MESA_USER_MASKED);
        manual_mask[`MESA_EV_FAN]  = (flim_q == `MESA_FAN_MASKED);
        manual_mask[`MESA_EV_TERM] = miscmask_q[0];
        manual_mask[`MESA_EV_VRD]  = miscmask_q[1];
    end
    wire [`MESA_EV_WIDTH-1:0] sleep_mask = deep ? {`MESA_EV_WIDTH{1'b1}} :
                                           (asleep ? slpmask_q : '0);
    wire [`MESA_EV_WIDTH-1:0] thr_bit = {{(`MESA_EV_WIDTH-1){1'b0}}, 1'b1} << `MESA_EV_THRTL;
    wire global_event_mask_bit = cfg_q[`MESA_CFG_GLOBAL_EVENT_MASK_BIT];
    wire [`MESA_EV_WIDTH-1:0] set_ev = cause &
        (thr_bit | ~(manual_mask | sleep_mask | {`MESA_EV_WIDTH{global_event_mask_bit}}));

    // ------------------------------------------------------------
    // error-status banks
    // ------------------------------------------------------------
    logic [`MESA_EV_WIDTH-1:0] cerr_q;
    logic [`MESA_EV_WIDTH-1:0] herr_q;
    logic [31:0]               prdata_q;
    wire [`MESA_EV_WIDTH-1:0] w1c = pwdata[`MESA_EV_WIDTH-1:0];
    // read clears controller bank in standard mode
    wire cerr_rdclr = rd & a_cer & cfg_q[`MESA_CFG_ALERT_STD];
    // clear only inactive causes
    // read-to-clear drops only the bits that the read reported
    wire [`MESA_EV_WIDTH-1:0] cclr = ((wr & a_cer) ? w1c : '0) |
                                     (cerr_rdclr ? prdata_q[`MESA_EV_WIDTH-1:0] : '0);
    wire [`MESA_EV_WIDTH-1:0] hclr = (wr & a_her) ? w1c : '0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cerr_q <= '0;
            herr_q <= '0;
        end else begin
            cerr_q <= (cerr_q & ~(cclr & ~cause)) | set_ev;
            herr_q <= (herr_q & ~(hclr & ~cause)) | set_ev;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    wire [`MESA_EV_WIDTH-1:0] drv = ~thr_bit;
    wire any_err = |((cerr_q | herr_q) & drv);
    assign alert_n = ~(any_err & cfg_q[`MESA_CFG_ALERT_EN]);
    assign controller_error_output = |(cerr_q & drv);
    assign host_error_output = |(herr_q & drv);

    // ------------------------------------------------------------
    // slave address, fixed at first transaction
    // ------------------------------------------------------------
    mesa_pkg::mesa_adr_type adr_q;
    logic [6:0] saddr_q;
    wire [6:0] sel_addr = sel_s[2] ? `MESA_SADDR_HIGH :
                          (sel_s[1] ? `MESA_SADDR_MID : `MESA_SADDR_LOW);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            adr_q   <= mesa_pkg::MESA_ADR_WAIT;
            saddr_q <= 7'h00;
        end else begin
            case (adr_q)
                mesa_pkg::MESA_ADR_WAIT: begin
                    if (bus_s) begin
                        saddr_q <= sel_addr;
                        adr_q   <= mesa_pkg::MESA_ADR_FIXED;
                    end
                end
                mesa_pkg::MESA_ADR_FIXED: adr_q <= mesa_pkg::MESA_ADR_FIXED;
                default: adr_q <= mesa_pkg::MESA_ADR_WAIT;
            endcase
        end
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    wire [31:0] rmux =
        a_cfg ? {28'h0, cfg_q} :
        a_slp ? {29'h0, sleep_q} :
        a_smk ? {22'h0, slpmask_q} :
        a_gmk ? {30'h0, gpimask_q} :
        a_mmk ? {30'h0, miscmask_q} :
        a_evt ? {22'h0, cause} :
        a_cer ? {22'h0, cerr_q} :
        a_her ? {22'h0, herr_q} :
        a_sad ? {24'h0, adr_q == mesa_pkg::MESA_ADR_FIXED, saddr_q} :
        a_chn ? {27'h0, channel} :
        a_vl  ? {24'h0, vlim_q} :
        a_tl  ? {24'h0, tlim_q} :
        a_fl  ? {24'h0, flim_q} :
        a_ul  ? {16'h0, ulim_q} :
        a_trk ? {31'h0, ulo_valid_q} : 32'h0;
    // captured in the setup cycle so the word stands unchanged through the access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0;
        end else if (psel & ~penable) begin
            prdata_q <= rmux;
        end
    end
    assign prdata = prdata_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_STICKY: assert property (@(posedge pclk) disable iff (!presetn)
        (cerr_q[0] && !cclr[0]) |=> cerr_q[0]) else $error("status bit lost");
    AST_W1C_ACTIVE: assert property (@(posedge pclk) disable iff (!presetn)
        (herr_q[1] && cause[1]) |=> herr_q[1]) else $error("active bit cleared");
    AST_BANKS: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && a_cer && herr_q[2]) |=> herr_q[2]) else $error("bank crosstalk");
    AST_MASKED: assert property (@(posedge pclk) disable iff (!presetn)
        (!cerr_q[0] && !set_ev[0]) |=> !cerr_q[0] || $past(cerr_rdclr))
        else $error("masked bit set");
    AST_ALERT_OFF: assert property (@(posedge pclk) disable iff (!presetn)
        !cfg_q[`MESA_CFG_ALERT_EN] |-> alert_n) else $error("alert not gated");
    AST_EXTRST: assert property (@(posedge pclk) disable iff (!presetn)
        ext_rst_edge |=> (sleep_q == `MESA_SLEEP_DEEP) && !locked && global_event_mask_bit)
        else $error("external reset effect missing");
    AST_THROTTLE: assert property (@(posedge pclk) disable iff (!presetn)
        (herr_q == thr_bit) && (cerr_q == thr_bit) |-> alert_n && !host_error_output)
        else $error("throttle drove outputs");
    AST_ADDR_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        (adr_q == mesa_pkg::MESA_ADR_FIXED) |=> $stable(saddr_q))
        else $error("slave address moved");
endmodule : mesa_monitor
`default_nettype wire

/* File: rtl/mesa_map.svh */
`ifndef MESA_MAP_SVH
`define MESA_MAP_SVH
// register byte addresses
`define MESA_ADDR_CONFIG     12'h000
`define MESA_ADDR_SLEEP      12'h004
`define MESA_ADDR_SLPMASK    12'h008
`define MESA_ADDR_GPIMASK    12'h00c
`define MESA_ADDR_MISCMASK   12'h010
`define MESA_ADDR_EVENTS     12'h014
`define MESA_ADDR_CTRL_ERR   12'h018
`define MESA_ADDR_HOST_ERR   12'h01c
`define MESA_ADDR_SLAVE      12'h020
`define MESA_ADDR_CHANNEL    12'h024
`define MESA_ADDR_VLIMIT     12'h028
`define MESA_ADDR_TLIMIT     12'h02c
`define MESA_ADDR_FLIMIT     12'h030
`define MESA_ADDR_ULIMIT     12'h034
`define MESA_ADDR_TRACKED    12'h038
// configuration bit positions
`define MESA_CFG_LOCK        0
`define MESA_CFG_GLOBAL_EVENT_MASK_BIT        1
`define MESA_CFG_ALERT_EN    2
`define MESA_CFG_ALERT_STD   3
// error-status bit positions
`define MESA_EV_VOLT         0
`define MESA_EV_TEMP         1
`define MESA_EV_DIODE        2
`define MESA_EV_GPI_LO       3
`define MESA_EV_GPI_HI       4
`define MESA_EV_USER_THR     5
`define MESA_EV_FAN          6
`define MESA_EV_TERM         7
`define MESA_EV_VRD          8
`define MESA_EV_THRTL        9
`define MESA_EV_WIDTH        10
// mask values
`define MESA_VOLT_MASKED     8'hff
`define MESA_TEMP_MASKED     8'h80
`define MESA_FAN_MASKED      8'hff
`define MESA_USER_MASKED     8'hff
// sleep state codes
`define MESA_SLEEP_S0        3'h0
`define MESA_SLEEP_DEEP      3'h4
// serial slave addresses
`define MESA_SADDR_LOW       7'h2c
`define MESA_SADDR_MID       7'h2e
`define MESA_SADDR_HIGH      7'h2d
// round robin
`define MESA_CHANNELS        5'd19
`define MESA_PASS_MS         100
`define MESA_CLK_HZ          25000000
`endif

/* File: rtl/mesa_pkg.sv */
package mesa_pkg;
    typedef enum logic [2:0] {
        MESA_SEL_LOW  = 3'b001,
        MESA_SEL_MID  = 3'b010,
        MESA_SEL_HIGH = 3'b100
    } mesa_sel_type;
    typedef enum logic [1:0] {
        MESA_ADR_WAIT  = 2'b01,
        MESA_ADR_FIXED = 2'b10
    } mesa_adr_type;
endpackage : mesa_pkg

/* File: rtl/mesa_round_robin.sv */
`timescale 1ns/10ps
`default_nettype none
`include "mesa_map.svh"
module mesa_round_robin #(
    parameter int unsigned SLOT_CYCLES = 100000
) (
    input  wire logic       pclk,
    input  wire logic       presetn,
    output logic [4:0]      channel_q,
    output logic            pass_done_q
);
    logic [31:0] slot_q;
    wire         slot_end = (slot_q == SLOT_CYCLES - 1);
    wire         last_ch  = (channel_q == `MESA_CHANNELS - 5'd1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slot_q      <= 32'h0;
            channel_q   <= 5'h0;
            pass_done_q <= 1'b0;
        end else begin
            pass_done_q <= slot_end && last_ch;
            slot_q      <= slot_end ? 32'h0 : slot_q + 32'h1;
            if (slot_end) begin
                channel_q <= last_ch ? 5'h0 : channel_q + 5'h1;
            end
        end
    end
endmodule : mesa_round_robin
`default_nettype wire

/* File: rtl/mesa_sync.sv */
`timescale 1ns/10ps
`default_nettype none
module mesa_sync #(
    parameter int W = 1
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] d,
    output logic [W-1:0]      q
);
    logic [W-1:0] meta_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule : mesa_sync
`default_nettype wire

/* File: test/mesa_serial_master.sv */
`timescale 1ns/10ps
`default_nettype none
// stand-in for the serial master: a frame raises bus activity while its clock runs;
// the link clock stands still between frames, as a real master's would
module mesa_serial_master (
    input  wire logic start,
    output logic      bus_activity,
    output logic      link_clk
);
    initial begin
        bus_activity = 1'b0;
        link_clk     = 1'b0;
    end
    always @(posedge start) begin
        bus_activity = 1'b1;
        repeat (18) #160 link_clk = ~link_clk;
        bus_activity = 1'b0;
    end
endmodule : mesa_serial_master
`default_nettype wire

/* File: test/test_monitor_error_status_and_alert.sv */
`timescale 1ns/10ps
`default_nettype none
`include "mesa_map.svh"
module test_monitor_error_status_and_alert;
    localparam int          SLOT = 4;
    localparam logic [11:0] CTL  = `MESA_ADDR_CTRL_ERR;
    localparam logic [11:0] HST  = `MESA_ADDR_HOST_ERR;
    localparam logic [11:0] CFG  = `MESA_ADDR_CONFIG;
    localparam logic [11:0] VL   = `MESA_ADDR_VLIMIT;
    logic        pclk, presetn, psel, penable, pwrite, start, ext_drv_n, link_clk, bus_act;
    logic        pready, pslverr, rst_o, rst_oe, ctrl_err, host_err, alert_n, pass_done;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, seed;
    logic [2:0]  addr_select;
    logic [9:0]  ev;
    logic [4:0]  channel;
    logic [32:0] exp_q[$];
    logic [6:0]  sadr[3] = '{7'b0101100, 7'b0101110, 7'b0101101};
    int          fails, n_checks, cyc, t0;
    // pull-up on the reset pin; either party may pull it low
    wire         ext_pin = ext_drv_n & (rst_oe | rst_o);

    mesa_monitor #(.SLOT_CYCLES(SLOT)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_reset_n_i(ext_pin), .ext_reset_n_o(rst_o), .ext_reset_n_oe(rst_oe),
        .addr_select(addr_select), .bus_activity(bus_act), .volt_event(ev[0]),
        .temp_event(ev[1]), .diode_event(ev[2]), .gpi_event(ev[4:3]),
        .user_throttle_event(ev[5]), .processor_throttle_signal(ev[9]), .fan_event(ev[6]),
        .termination_sense_input(ev[7]), .regulator_overheat_input(ev[8]),
        .controller_error_output(ctrl_err), .host_error_output(host_err), .alert_n(alert_n),
        .channel(channel), .pass_done(pass_done));

    mesa_serial_master far_u (.start(start), .bus_activity(bus_act), .link_clk(link_clk));

    always #20 pclk = ~pclk;

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {1'b0, x[31:1]} ^ (x[0] ? 32'h80200003 : 32'h0);
    endfunction : lfsr

    task close_out;
        if (fails == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : close_out

    task automatic check(input logic [32:0] got, input logic [32:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask : check

    task tick(input int n);
        repeat (n) @(posedge pclk);
    endtask : tick

    // one transfer; the expected {pslverr, read data} goes on the queue
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        exp_q.push_back(e);
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0);
    endtask : wr

    task rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, {1'b0, e});
    endtask : rd

    // causes pass two synchronising flops, so give them a few cycles
    task set_ev(input logic [9:0] v);
        @(posedge pclk);
        ev <= v;
        tick(4);
    endtask : set_ev

    task outs(input logic [2:0] e);
        tick(1);
        check({30'h0, alert_n, ctrl_err, host_err}, {30'h0, e});
    endtask : outs

    task do_reset;
        @(posedge pclk);
        presetn <= 1'b0;
        tick(6);
        presetn <= 1'b1;
    endtask : do_reset

    always @(posedge pclk)
        if (psel && penable && pready === 1'b1)
            check({pslverr, pwrite ? 32'h0 : prdata}, exp_q.pop_front());

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            close_out();
        end
    end

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        {psel, penable, pwrite, start} = 4'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        ev = 10'h0;
        ext_drv_n = 1'b1;
        addr_select = 3'b001;
        seed = 32'h6356f42c;
        fails = 0;
        n_checks = 0;
        cyc = 0;
        // ----------------------------------------
        // address pinned at the first transaction
        // ----------------------------------------
        for (int k = 0; k < 3; k++) begin
            do_reset();
            addr_select <= 3'b001 << k;
            start <= 1'b1;
            tick(80);
            start <= 1'b0;
            addr_select <= 3'b001 << ((k + 1) % 3);
            rd(`MESA_ADDR_SLAVE, {24'h0, 1'b1, sadr[k]});
        end
        @(posedge pass_done);
        t0 = cyc;
        @(posedge pass_done);
        check(33'(cyc - t0), 33'(19 * SLOT));
        tick(1);
        check({28'h0, channel}, 33'h0);
        rd(CFG, 32'h0);
        rd(VL, 32'hff);
        rd(`MESA_ADDR_TLIMIT, 32'h80);
        rd(`MESA_ADDR_FLIMIT, 32'hff);
        apb(1'b0, 12'h0fc, 32'h0, {1'b1, 32'h0});
        apb(1'b1, `MESA_ADDR_ULIMIT, 32'h100, {1'b1, 32'h0});
        for (int i = 0; i < 3; i++) begin
            seed = lfsr(seed);
            wr(`MESA_ADDR_SLPMASK, seed);
            rd(`MESA_ADDR_SLPMASK, seed & 32'h3ff);
        end
        wr(`MESA_ADDR_SLEEP, 32'h0);
        wr(VL, 32'h10);
        wr(`MESA_ADDR_TLIMIT, 32'h10);
        wr(`MESA_ADDR_FLIMIT, 32'h10);
        wr(`MESA_ADDR_ULIMIT, 32'h010);
        wr(`MESA_ADDR_ULIMIT, 32'h100);
        set_ev(10'h001);
        outs(3'b111);
        wr(CFG, 32'h4);
        outs(3'b011);
        wr(CTL, 32'h1);
        rd(CTL, 32'h1);
        set_ev(10'h0);
        rd(CTL, 32'h1);
        wr(CTL, 32'h3ff);
        wr(HST, 32'h3ff);
        outs(3'b100);
        // every cause sets both banks once unmasked
        for (int i = 0; i < 10; i++) begin
            set_ev(10'h001 << i);
            set_ev(10'h0);
            rd(CTL, 32'h1 << i);
            outs(i == 9 ? 3'b100 : 3'b011);
            wr(CTL, 32'h3ff);
            rd(HST, 32'h1 << i);
            wr(HST, 32'h3ff);
        end
        set_ev(10'h001);
        set_ev(10'h0);
        wr(VL, 32'hff);
        wr(`MESA_ADDR_TLIMIT, 32'h80);
        wr(`MESA_ADDR_FLIMIT, 32'hff);
        wr(`MESA_ADDR_ULIMIT, 32'h0ff);
        wr(`MESA_ADDR_ULIMIT, 32'h100);
        wr(`MESA_ADDR_GPIMASK, 32'h3);
        wr(`MESA_ADDR_MISCMASK, 32'h3);
        set_ev(10'h3fe);
        set_ev(10'h0);
        rd(CTL, 32'h201);
        wr(CTL, 32'h3ff);
        wr(HST, 32'h3ff);
        wr(VL, 32'h10);
        wr(CFG, 32'hc);
        set_ev(10'h001);
        set_ev(10'h0);
        rd(CTL, 32'h1);
        rd(CTL, 32'h0);
        rd(HST, 32'h1);
        rd(HST, 32'h1);
        wr(HST, 32'h3ff);
        wr(CFG, 32'h1);
        wr(VL, 32'h55);
        rd(VL, 32'h10);
        @(posedge pclk);
        ext_drv_n <= 1'b0;
        tick(4);
        ext_drv_n <= 1'b1;
        tick(4);
        rd(CFG, 32'h2);
        rd(`MESA_ADDR_SLEEP, 32'h4);
        wr(CFG, 32'h0);
        set_ev(10'h001);
        set_ev(10'h0);
        rd(CTL, 32'h0);
        wr(`MESA_ADDR_SLPMASK, 32'h1);
        wr(`MESA_ADDR_SLEEP, 32'h1);
        set_ev(10'h001);
        set_ev(10'h0);
        rd(CTL, 32'h0);
        wr(`MESA_ADDR_SLEEP, 32'h0);
        set_ev(10'h001);
        set_ev(10'h0);
        rd(CTL, 32'h1);
        close_out();
    end
endmodule : test_monitor_error_status_and_alert
`default_nettype wire
